// [core/halt_power_mode_control.sv]
// Halt instruction sequencing: timed sleep, full stop and wake-up.
// Assumes CPU presents executed opcodes with a valid strobe, and that
// time-base and other interrupts arrive on MCLK; wake pins are async.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: Halt with interrupt enable set: timed sleep
// R2: Halt with interrupt enable clear: full stop
// R3: Timed sleep wakes on time-base or reset
// R4: Time-base wake skips stabilisation delay
// R5: Reset wake from timed sleep waits delay
// R6: Sleep entry forces mask level to 10
// R7: Timed sleep: only oscillator and time-base run
// R8: Timed sleep never triggers watchdog reset
// R9: Software keeps enable set during delay
// R10: Early enable clear falls into stop
// R11: Stop wake restarts oscillator, waits delay
// R12: Stop wakes on reset or pin interrupt
// R13: Full stop turns oscillator off
// R14: Watchdog option turns halt into reset
// R15: Service wake interrupt with stacked mask
// R16: Opcode 0x8E decodes as halt
// R17: Software arms a pin wake source
// R18: Software clears stale interrupt flags first
// R19: Delay counted on oscillator, CPU gated
// R20: Wake completion returns to run
module halt_power_mode_control (
  input  wire logic                       MCLK,
  input  wire logic                       SRST,
  input  wire logic                       CE,
  input  wire logic                       INSTR_VALID,
  input  wire logic [7:0]                 OPCODE,
  input  wire logic                       TIMEBASE_IRQ,
  input  wire logic                       WDG_ENABLED,
  input  wire logic                       EXT_WAKE_PIN,
  input  wire logic                       RESET_WAKE_PIN,
  input  wire logic                       OPT_LONG_DELAY,
  input  wire logic                       WATCHDOG_SLEEP_OPTION,
  input  wire logic [halt_pm_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [7:0]                 WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [7:0]                 RDATA,
  output halt_pm_pkg::clk_gate_s          CLK_GATES,
  output logic                            MASK_FORCE,
  output logic      [1:0]                 MASK_LEVEL,
  output logic                            SERVICE_IRQ,
  output logic                            FETCH_RESET,
  output logic                            WDG_RESET_REQ,
  output logic                            OSC_IRQ_EN
);
  import halt_pm_pkg::*;

  // Only a valid executed opcode counts, never a fetched data byte
  // Halt opcode recogniser
  function automatic logic is_halt(input logic [7:0] op);
    is_halt = (op == HALT_OPCODE); // R16
  endfunction

  // Clock gates that belong to each mode
  // Gates come from a register, so a mode change never glitches a clock;
  // the price is one cycle between the decision and the gate edge.
  function automatic clk_gate_s gates_of(input pm_state_e st);
    clk_gate_s g;
    g = GATES_ALL_OFF;
    case (st)
      PM_RUN, PM_GUARD: g = GATES_ALL_ON; // R20
      PM_TSLEEP: begin
        g.osc      = 1'h1; // R7
        g.timebase = 1'h1; // R7
      end
      PM_STOP:   g = GATES_ALL_OFF; // R13
      PM_STAB:   g.osc = 1'h1; // R19
      // Remaining delay is counted with the oscillator on
      PM_REMAIN: g.osc = 1'h1;
      default:   g = GATES_ALL_ON;
    endcase
    gates_of = g;
  endfunction

  // Synchronised pin levels
  // Pins are slow and may bounce, so three flops plus agreement cost
  // four cycles of wake latency; that is small beside the delay count.
  logic [1:0] pin_lvl;    // [0] pin wake, [1] reset wake
  logic       ext_wake;   // Clockless wake source
  logic       rst_wake;   // Reset request during sleep

  // Options and enable survive every wake; reset loads both, and software writes also change the enable
  // Mode state
  pm_state_e  state_reg;       // Current power mode
  pm_state_e  state_next;
  logic       wake_rst_reg;    // Wake cause is a reset
  logic       wake_rst_next;
  logic       oie_reg;         // osc_interrupt_enable
  logic       oie_next;
  logic       opt_long_reg;    // Option: long delay
  logic       opt_wdg_reg;     // Option: watchdog_sleep_option
  clk_gate_s  gates_reg;       // Registered clock gates
  clk_gate_s  gates_next;

  // Each pulse lasts one enabled cycle and then drops by itself
  // CPU event pulses
  logic       mask_reg;        // Mask level forced this cycle
  logic       mask_next;
  logic       svc_reg;         // Service waking interrupt
  logic       svc_next;
  logic       fetch_reg;       // Fetch reset vector
  logic       fetch_next;
  logic       wdg_reg;         // Watchdog reset instead of stop
  logic       wdg_next;

  // Register read path
  logic [7:0] rdata_reg;       // Valid only in the cycle after RD
  logic [7:0] rdata_next;

  // Stabilisation counter handshake
  // The counter stops while the oscillator is off, so a halt during the
  // guard window into full stop parks the count until the next restart.
  logic       stab_start;      // Restart the delay count
  logic       stab_run;        // Oscillator live for counting
  logic       stab_done;       // Delay elapsed
  logic       halt_exec;       // Halt executed this cycle

  // Pin inputs pass the agreement filter
  pm_pin_sync #(
    .W (2)
  ) u_sync (
    .clk   (MCLK),
    .srst  (SRST),
    .ce    (CE),
    .pin   ({RESET_WAKE_PIN, EXT_WAKE_PIN}),
    .level (pin_lvl)
  );

  assign ext_wake = pin_lvl[0];
  assign rst_wake = pin_lvl[1];

  // Delay counter advances only while the oscillator is on
  pm_stab_counter u_stab (
    .clk      (MCLK),
    .srst     (SRST),
    .ce       (CE),
    .start    (stab_start),
    .run      (stab_run),
    .long_sel (opt_long_reg),
    .done     (stab_done)
  );

  // Halt is taken only while the CPU runs, in RUN or GUARD
  assign halt_exec = INSTR_VALID && is_halt(OPCODE); // R16
  assign stab_run  = gates_reg.osc; // R19

  // Mode sequencing and register port
  always_comb begin
    state_next    = state_reg;
    wake_rst_next = wake_rst_reg;
    oie_next      = oie_reg;
    mask_next     = 1'h0;
    svc_next      = 1'h0;
    fetch_next    = 1'h0;
    wdg_next      = 1'h0;
    stab_start    = 1'h0;
    rdata_next    = 8'h00;

    // Writes are accepted in every mode; the CPU only writes while clocked
    // Software write to the control register
    if (WR && (ADDR == ADDR_CTRL)) begin
      oie_next = WDATA[OIE_BIT];
    end

    case (state_reg)
      // Running, possibly inside the post-wake guard window
      PM_RUN, PM_GUARD: begin
        if (state_reg == PM_GUARD && stab_done) begin
          state_next = PM_RUN; // R20
        end else if (state_reg == PM_GUARD && !oie_reg) begin
          // Enable dropped before the delay ran out
          state_next = PM_REMAIN; // R10
        end
        // A halt beats the guard window's own transitions
        if (halt_exec) begin
          if (oie_reg) begin
            // Time-base bounds the sleep, so no watchdog reset
            state_next = PM_TSLEEP; // R1 R8
            mask_next  = 1'h1; // R6
          end else if (WDG_ENABLED && opt_wdg_reg) begin
            // Option turns the halt into a watchdog reset
            wdg_next   = 1'h1; // R14
            state_next = PM_RUN;
          end else begin
            state_next = PM_STOP; // R2
            mask_next  = 1'h1; // R6
          end
        end
      end

      // Timed sleep: reset has priority over time-base
      // Every other interrupt is refused here and stays pending upstream
      PM_TSLEEP: begin
        if (rst_wake) begin
          state_next    = PM_STAB; // R3 R5
          wake_rst_next = 1'h1;
          stab_start    = 1'h1; // R5
        end else if (TIMEBASE_IRQ) begin
          // Serve at once; watch the enable for the delay length
          state_next    = PM_GUARD; // R3 R4 R9
          wake_rst_next = 1'h0;
          svc_next      = 1'h1; // R4 R15
          stab_start    = 1'h1;
        end
      end

      // Full stop: only clockless sources or reset wake it
      // Time-base cannot wake it: its counter has no clock in this mode
      PM_STOP: begin
        if (rst_wake || ext_wake) begin
          state_next    = PM_STAB; // R11 R12
          wake_rst_next = rst_wake;
          stab_start    = 1'h1; // R11
        end
      end

      // Oscillator restarted, CPU held until the count ends
      // The wake cause chooses reset fetch or interrupt service
      PM_STAB: begin
        if (stab_done) begin
          state_next = PM_RUN; // R19 R20
          fetch_next = wake_rst_reg; // R11
          svc_next   = !wake_rst_reg; // R11 R15
        end
      end

      // Stop-like hold for what is left of the delay
      // Halt is ignored here since the CPU clock is gated
      PM_REMAIN: begin
        if (stab_done) begin
          state_next = PM_RUN; // R10 R20
        end
      end

      // Unused codes fall back to run
      default: state_next = PM_RUN;
    endcase

    // Gates follow the next mode so they change with the state register
    gates_next = gates_of(state_next);

    // Read data for the cycle after the strobe
    if (RD) begin
      case (ADDR)
        ADDR_CTRL: rdata_next[OIE_BIT] = oie_reg;
        ADDR_STATUS: begin
          rdata_next[ST_MODE_LSB +: 3] = state_reg;
          rdata_next[ST_LONG_BIT]      = opt_long_reg;
          rdata_next[ST_WDG_BIT]       = opt_wdg_reg;
          rdata_next[ST_RST_BIT]       = wake_rst_reg;
        end
        // Unmapped addresses read as zero
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // State registers; option straps caught while reset is held
  // Straps are only sampled in reset, so a strap change at run time is
  // ignored until the next reset; reset itself ignores the clock enable
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_reg    <= PM_RUN;
      wake_rst_reg <= 1'h0;
      oie_reg      <= OIE_RESET;
      opt_long_reg <= OPT_LONG_DELAY;
      opt_wdg_reg  <= WATCHDOG_SLEEP_OPTION;
      gates_reg    <= GATES_ALL_ON;
      mask_reg     <= 1'h0;
      svc_reg      <= 1'h0;
      fetch_reg    <= 1'h0;
      wdg_reg      <= 1'h0;
      rdata_reg    <= 8'h00;
    end else if (CE) begin
      state_reg    <= state_next;
      wake_rst_reg <= wake_rst_next;
      oie_reg      <= oie_next;
      gates_reg    <= gates_next;
      mask_reg     <= mask_next;
      svc_reg      <= svc_next;
      fetch_reg    <= fetch_next;
      wdg_reg      <= wdg_next;
      rdata_reg    <= rdata_next;
    end
  end

  // The mask level is fixed; MASK_FORCE says when the CPU must apply it
  // Outputs from flip-flops, except the constant MASK_LEVEL
  assign RDATA         = rdata_reg;
  assign CLK_GATES     = gates_reg;
  assign MASK_FORCE    = mask_reg;
  assign MASK_LEVEL    = SLEEP_MASK_LEVEL; // R6
  assign SERVICE_IRQ   = svc_reg;
  assign FETCH_RESET   = fetch_reg;
  assign WDG_RESET_REQ = wdg_reg;
  assign OSC_IRQ_EN    = oie_reg;
endmodule // halt_power_mode_control
`default_nettype wire

// [core/halt_pm_pkg.sv]
// Shared constants and types for the halt power mode controller.
// Assumes a single 10 MHz main clock and an 8-bit register port.
package halt_pm_pkg;

  // Clock rate and instruction cycle
  localparam int MCLK_PERIOD_NS  = 100;  // Main clock period
  localparam int CPU_CYCLE_NS    = 100;  // One cpu_cycle_period

  // Oscillator stabilisation delay, in CPU cycles
  localparam int STAB_SHORT_CPU_CYCLE_PERIOD = 256;
  localparam int STAB_LONG_CPU_CYCLE_PERIOD  = 4096;
  localparam int STAB_SHORT_CYC  = STAB_SHORT_CPU_CYCLE_PERIOD * CPU_CYCLE_NS / MCLK_PERIOD_NS;
  localparam int STAB_LONG_CYC   = STAB_LONG_CPU_CYCLE_PERIOD * CPU_CYCLE_NS / MCLK_PERIOD_NS;
  localparam int STAB_CNT_W      = 12;   // Holds the longest count minus one

  // Halt opcode
  localparam logic [7:0] HALT_OPCODE = 8'h8E;

  // Interrupt mask level forced on entry to sleep
  localparam logic [1:0] SLEEP_MASK_LEVEL = 2'h2;

  // Register port
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;  // main_clock_status_reg
  localparam logic [3:0]  ADDR_STATUS = 4'h1;  // Mode status
  localparam int          OIE_BIT     = 0;     // Control: interrupt enable
  localparam logic        OIE_RESET   = 1'h0;
  localparam int          ST_MODE_LSB = 0;     // Status: mode code [2:0]
  localparam int          ST_LONG_BIT = 3;     // Status: long delay option
  localparam int          ST_WDG_BIT  = 4;     // Status: watchdog sleep option
  localparam int          ST_RST_BIT  = 5;     // Status: last wake was reset

  // Power modes
  typedef enum logic [2:0] {
    PM_RUN, PM_TSLEEP, PM_STOP, PM_STAB, PM_GUARD, PM_REMAIN
  } pm_state_e;

  // Clock gate bundle
  typedef struct packed {
    logic osc;       // Main oscillator running
    logic timebase;  // Time-base counter clock
    logic cpu;       // CPU clock
    logic periph;    // Peripheral clocks
  } clk_gate_s;

  localparam clk_gate_s GATES_ALL_ON  = 4'hF;
  localparam clk_gate_s GATES_ALL_OFF = 4'h0;

endpackage

// [core/pm_pin_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to MCLK; output moves once stages agree.
`timescale 1ns/1ns
`default_nettype none
module pm_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  import halt_pm_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;    // First stage, read only by s2
      logic s2_reg;    // Second stage
      logic s3_reg;    // Third stage
      logic lvl_reg;   // Filtered level
      logic lvl_next;

      // Take a change only when two settled stages agree
      always_comb begin
        lvl_next = lvl_reg;
        if (s2_reg == s3_reg) begin
          lvl_next = s2_reg;
        end
      end

      // Shift chain, frozen by clock enable
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_reg  <= 1'h0;
          s2_reg  <= 1'h0;
          s3_reg  <= 1'h0;
          lvl_reg <= 1'h0;
        end else if (ce) begin
          s1_reg  <= pin[i];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          lvl_reg <= lvl_next;
        end
      end

      assign level[i] = lvl_reg;
    end
  endgenerate
endmodule // pm_pin_sync
`default_nettype wire

// [core/pm_stab_counter.sv]
// Oscillator stabilisation counter with selectable length.
// Assumes run is high only while the oscillator is on.
`timescale 1ns/1ns
`default_nettype none
module pm_stab_counter (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic run,
  input  wire logic long_sel,
  output logic      done
);
  import halt_pm_pkg::*;

  localparam logic [STAB_CNT_W-1:0] LAST_SHORT = STAB_CNT_W'(STAB_SHORT_CYC - 1);
  localparam logic [STAB_CNT_W-1:0] LAST_LONG  = STAB_CNT_W'(STAB_LONG_CYC - 1);

  logic [STAB_CNT_W-1:0] cnt_reg;   // Cycles counted so far
  logic [STAB_CNT_W-1:0] cnt_next;
  logic                  act_reg;   // Count in progress
  logic                  act_next;
  logic                  done_reg;  // One-cycle completion pulse
  logic                  done_next;
  logic [STAB_CNT_W-1:0] last;      // Selected final value

  // Count only on live oscillator cycles; start always restarts
  always_comb begin
    last      = long_sel ? LAST_LONG : LAST_SHORT;
    cnt_next  = cnt_reg;
    act_next  = act_reg;
    done_next = 1'h0;
    if (start) begin
      cnt_next = '0;
      act_next = 1'h1;
    end else if (act_reg && run) begin
      if (cnt_reg == last) begin
        act_next  = 1'h0;
        done_next = 1'h1;
      end else begin
        cnt_next = cnt_reg + 1'h1;
      end
    end
  end

  // Counter state
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      act_reg  <= 1'h0;
      done_reg <= 1'h0;
    end else if (ce) begin
      cnt_reg  <= cnt_next;
      act_reg  <= act_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule // pm_stab_counter
`default_nettype wire

// [tb/halt_pm_props.sv]
// Timing checks on the halt sequencer's ports.
// Assumes a single MCLK domain with SRST synchronous.
`timescale 1ns/1ns
`default_nettype none
module halt_pm_props (
  input wire logic                  MCLK,
  input wire logic                  SRST,
  input wire logic                  CE,
  input wire logic                  INSTR_VALID,
  input wire logic [7:0]            OPCODE,
  input wire logic                  TIMEBASE_IRQ,
  input wire logic                  WDG_ENABLED,
  input wire logic                  WATCHDOG_SLEEP_OPTION,
  input wire halt_pm_pkg::clk_gate_s CLK_GATES,
  input wire logic                  MASK_FORCE,
  input wire logic [1:0]            MASK_LEVEL,
  input wire logic                  SERVICE_IRQ,
  input wire logic                  FETCH_RESET,
  input wire logic                  WDG_RESET_REQ,
  input wire logic                  OSC_IRQ_EN
);
  import halt_pm_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  logic halt_now;  // Halt taken while fully clocked
  logic wdg_halt;  // Halt turns into watchdog reset
  assign halt_now = CE && INSTR_VALID && (OPCODE == 8'h8E) && (CLK_GATES == 4'hF);
  assign wdg_halt = WDG_ENABLED && WATCHDOG_SLEEP_OPTION;
  a_halt_sleep: assert property (
    halt_now && OSC_IRQ_EN |=> CLK_GATES == 4'hC && MASK_FORCE) else $error("no timed sleep");
  a_halt_stop: assert property (
    halt_now && !OSC_IRQ_EN && !wdg_halt |=> CLK_GATES == 4'h0 && MASK_FORCE)
    else $error("no full stop");
  a_wdg_reset: assert property (
    halt_now && !OSC_IRQ_EN && wdg_halt |=> WDG_RESET_REQ && CLK_GATES == 4'hF)
    else $error("no watchdog reset");
  a_mask_level: assert property (
    MASK_FORCE |-> MASK_LEVEL == 2'h2 && (CLK_GATES == 4'hC || CLK_GATES == 4'h0))
    else $error("mask level wrong");
  a_tb_wake: assert property (
    CE && CLK_GATES == 4'hC && TIMEBASE_IRQ |=> SERVICE_IRQ && CLK_GATES == 4'hF)
    else $error("time-base wake late");
  a_osc_first: assert property (
    CLK_GATES == 4'h0 |=> CLK_GATES inside {4'h0, 4'h8}) else $error("cpu clocked early");
  a_stab_min: assert property (
    $rose(CLK_GATES.osc) && !CLK_GATES.cpu |-> (CLK_GATES == 4'h8) [*8])
    else $error("delay cut short");
  a_wake_run: assert property ((SERVICE_IRQ || FETCH_RESET) |-> CLK_GATES == 4'hF)
    else $error("wake without clocks");
endmodule // halt_pm_props
bind halt_power_mode_control halt_pm_props i_props (.MCLK, .SRST, .CE, .INSTR_VALID,
  .OPCODE, .TIMEBASE_IRQ, .WDG_ENABLED, .WATCHDOG_SLEEP_OPTION, .CLK_GATES, .MASK_FORCE,
  .MASK_LEVEL, .SERVICE_IRQ, .FETCH_RESET, .WDG_RESET_REQ, .OSC_IRQ_EN);
`default_nettype wire

// [tb/pm_cpu_model.sv]
// Stand-in for the CPU core and the wake sources.
// Assumes one MCLK; all lines move by NBA on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module pm_cpu_model (
  input  wire logic       clk,
  input  wire logic       served,
  output logic            instr_valid,
  output logic      [7:0] opcode,
  output logic            timebase_irq,
  output logic            ext_pin,
  output logic            rst_pin
);
  // Idle: no opcode, pins at their pulled-down level
  initial begin
    instr_valid  = 1'b0;
    opcode       = 8'h00;
    timebase_irq = 1'b0;
    ext_pin      = 1'b0;
    rst_pin      = 1'b0;
  end
  // One executed opcode, other requests quiet beforehand
  task automatic exec(input logic [7:0] op);
    @(posedge clk);
    instr_valid <= 1'b1;
    opcode      <= op;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  // Request stays pending until served or n edges pass
  task automatic tick(input int n, output int k);
    k = 0;
    @(posedge clk);
    timebase_irq <= 1'b1;
    while (k < n && !served) begin
      @(posedge clk);
      k++;
    end
    timebase_irq <= 1'b0;
  endtask
  // Wake pin held long enough to pass the filter
  task automatic pin(input logic rst);
    @(posedge clk);
    if (rst) begin
      rst_pin <= 1'b1;
    end else begin
      ext_pin <= 1'b1;
    end
    repeat (6) @(posedge clk);
    rst_pin <= 1'b0;
    ext_pin <= 1'b0;
  endtask
endmodule // pm_cpu_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the halt sequencer.
// Assumes the package constants and the CPU stand-in model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import halt_pm_pkg::*;
  logic       mclk, srst, ce, wdg_en, long_opt, wdg_opt, wr, rd;
  logic       iv, tbi, ext, rstp, mask_force, service_irq, fetch_rst, wdg_rst, osc_interrupt_enable;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, opcode, dout;
  logic [1:0] mask_level;
  clk_gate_s  gates;
  int         fail_count, samples_checked;
  halt_power_mode_control i_halt_power_mode_control (.MCLK(mclk), .SRST(srst), .CE(ce),
    .INSTR_VALID(iv), .OPCODE(opcode), .TIMEBASE_IRQ(tbi), .WDG_ENABLED(wdg_en),
    .EXT_WAKE_PIN(ext), .RESET_WAKE_PIN(rstp), .OPT_LONG_DELAY(long_opt),
    .WATCHDOG_SLEEP_OPTION(wdg_opt), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CLK_GATES(gates), .MASK_FORCE(mask_force), .MASK_LEVEL(mask_level),
    .SERVICE_IRQ(service_irq), .FETCH_RESET(fetch_rst), .WDG_RESET_REQ(wdg_rst),
    .OSC_IRQ_EN(osc_interrupt_enable));
  pm_cpu_model cpu (.clk(mclk), .served(service_irq), .instr_valid(iv), .opcode(opcode),
    .timebase_irq(tbi), .ext_pin(ext), .rst_pin(rstp));
  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Verdict and stop
  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Straps are latched while reset is held
  task automatic do_reset(input logic lg, input logic wd);
    @(posedge mclk);
    srst     <= 1'b1;
    long_opt <= lg;
    wdg_opt  <= wd;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
  endtask
  // Register write, one strobe cycle
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  // Register read, data stands only in the next cycle
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait for a gate pattern; n counts edges spent
  task automatic wait_g(input clk_gate_s v, output int n);
    n = 0;
    while (gates !== v) begin
      @(posedge mclk);
      #1 n++;
      if (n > 5000) begin
        fail_count++;
        end_of_test();
      end
    end
  endtask
  // Main sequence
  initial begin
    int n;
    int k;
    {ce, wdg_en, srst} = 3'h7;
    {long_opt, wdg_opt, wr, rd, addr, wdata} = '0;
    do_reset(1'b0, 1'b0);
    #1 `CHK(gates, 4'hF)
    reg_rd(4'h1, dout);
    `CHK(dout, 8'h00)
    reg_rd(4'h7, dout);
    `CHK(dout, 8'h00)
    cpu.exec(8'h8D);
    #1 `CHK({gates, mask_force}, 5'h1E)
    cpu.exec(HALT_OPCODE);
    #1 `CHK({gates, mask_force, mask_level}, 7'h06)
    cpu.tick(5, k);
    #1 `CHK(gates, 4'h0)
    fork cpu.pin(1'b0); join_none
    wait_g(4'h8, n);
    wait_g(4'hF, n);
    `CHK(n, STAB_SHORT_CYC + 1)
    `CHK(service_irq, 1'b1)
    reg_wr(4'h0, 8'h01);
    `CHK(osc_interrupt_enable, 1'b1)
    cpu.exec(HALT_OPCODE);
    #1 `CHK({gates, mask_force, wdg_rst}, 6'h32)
    fork cpu.pin(1'b0); join_none
    repeat (12) @(posedge mclk);
    #1 `CHK(gates, 4'hC)
    cpu.tick(20, k);
    `CHK(k, 2)
    #1 `CHK(gates, 4'hF)
    reg_wr(4'h0, 8'h00);
    wait_g(4'h8, n);
    `CHK(n <= 1, 1'b1)
    wait_g(4'hF, n);
    `CHK(n < STAB_SHORT_CYC, 1'b1)
    reg_wr(4'h0, 8'h01);
    cpu.exec(HALT_OPCODE);
    fork cpu.pin(1'b1); join_none
    wait_g(4'h8, n);
    wait_g(4'hF, n);
    `CHK(n, STAB_SHORT_CYC + 1)
    `CHK(fetch_rst, 1'b1)
    reg_rd(4'h1, dout);
    `CHK(dout, 8'h20)
    @(posedge mclk);
    #1 `CHK(rdata, 8'h00)
    do_reset(1'b1, 1'b1);
    cpu.exec(HALT_OPCODE);
    #1 `CHK({gates, wdg_rst}, 5'h1F)
    reg_rd(4'h1, dout);
    `CHK(dout, 8'h18)
    reg_wr(4'h0, 8'h01);
    cpu.exec(HALT_OPCODE);
    #1 `CHK({gates, mask_force, wdg_rst}, 6'h32)
    cpu.tick(20, k);
    reg_rd(4'h1, dout);
    `CHK(dout, 8'h1C)
    repeat (STAB_LONG_CYC) @(posedge mclk);
    reg_rd(4'h1, dout);
    `CHK(dout, 8'h18)
    do_reset(1'b1, 1'b0);
    cpu.exec(HALT_OPCODE);
    fork cpu.pin(1'b0); join_none
    wait_g(4'h8, n);
    wait_g(4'hF, n);
    `CHK(n, STAB_LONG_CYC + 1)
    end_of_test();
  end
endmodule // tb
`default_nettype wire
